// *** rtl/rscb_params.svh ***
// Constants of the reset strap, clock and serial boot block.
// Assumes both ends run on one 125 MHz sys_clk standing for the oscillator.
// Notes on behaviour
// [RULE1] Sample six interrupt lines as straps during reset
// [RULE2] Top strap bit picks 128 or 64-bit bus
// [RULE3] Low three bits pick divisor 2..8, 111 also 8
// [RULE4] Link transfers follow rising edges of clock A
// [RULE5] Bits 4:3 delay clock B by 0..3 core cycles
// [RULE6] Both system clocks same period, complementary pairs
// [RULE7] Core clock is oscillator divided by two
// [RULE8] System logic may use clock A pair two-phase
// [RULE9] Power-good low keeps device in reset
// [RULE10] Hold power-good low until reference settles
// [RULE11] After reset, load boot ROM into instruction cache
// [RULE12] Drive ROM enable and clock, one bit each
// [RULE13] After load, execute from address zero
// [RULE14] Line fill comes as two 16-byte transfers, four 8-byte ones on the 64-bit bus
// [RULE15] Latch straps at reset release, hold until reset
`ifndef RSCB_PARAMS_SVH
`define RSCB_PARAMS_SVH
`define RSCB_STRAP_W 6
`define RSCB_WIDE_BIT 5
`define RSCB_DIV_LSB 0
`define RSCB_DLY_LSB 3
`define RSCB_RATIO_MIN 4'h2
`define RSCB_RATIO_MAX 4'h8
`define RSCB_DIV_SAT 3'h7
`define RSCB_ROM_HALF 3'h4
`define RSCB_BOOT_PC 32'h0
`define RSCB_CLK_PERIOD_NS 8
`define RSCB_REF_SETTLE_NS 1000
`define RSCB_REF_SETTLE_CYC \
    ((`RSCB_REF_SETTLE_NS + `RSCB_CLK_PERIOD_NS - 1) / `RSCB_CLK_PERIOD_NS)
`define RSCB_BUS_W 128
`define RSCB_NARROW_W 64
`define RSCB_LINE_W 256
`define RSCB_ADDR_W 29
`define RSCB_WIDE_BEATS 3'h2
`define RSCB_NARROW_BEATS 3'h4
`endif

// *** rtl/rscb_pkg.sv ***
// Types shared by both ends of the strap, clock and boot link.
// Assumes rscb_params.svh supplies the numeric constants.
package rscb_pkg;
    typedef enum logic [3:0] {
        DEV_HELD = 4'h1,
        DEV_BOOT = 4'h2,
        DEV_RUN = 4'h4,
        DEV_FILL = 4'h8
    } rscb_dev_state_t;
    typedef enum logic [3:0] {
        SYS_IDLE = 4'h1,
        SYS_LOAD = 4'h2,
        SYS_SERVE = 4'h4,
        SYS_DONE = 4'h8
    } rscb_sys_state_t;
endpackage

// *** rtl/rscb_if.sv ***
// Link between the processor end and the system logic end.
// Assumes both ends clock on the same sys_clk; the bench joins them.
`timescale 1ns/100ps
`default_nettype none
`include "rscb_params.svh"
interface rscb_if;
    logic [`RSCB_STRAP_W-1:0] straps;
    logic powerGood;
    logic resetIn_n;
    logic clkAPos;
    logic clkANeg;
    logic clkBPos;
    logic clkBNeg;
    logic romOe;
    logic romClk;
    logic romData;
    logic fillReq;
    logic [`RSCB_ADDR_W-1:0] fillAddr;
    logic fillValid;
    logic [`RSCB_BUS_W-1:0] fillData;
    modport dev (
        input straps, powerGood, resetIn_n, romData, fillValid, fillData,
        output clkAPos, clkANeg, clkBPos, clkBNeg, romOe, romClk, fillReq, fillAddr
    );
    modport sys (
        output straps, powerGood, resetIn_n, romData, fillValid, fillData,
        input clkAPos, clkANeg, clkBPos, clkBNeg, romOe, romClk, fillReq, fillAddr
    );
endinterface
`default_nettype wire

// *** rtl/rscb_device.sv ***
// Processor end: strap capture, core and system clocks, serial boot, fills.
// Assumes sys_clk is the oscillator and link pins come from another chip.
`timescale 1ns/100ps
`default_nettype none
`include "rscb_params.svh"
module rscb_device #(
    parameter int ICACHE_WORDS = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    rscb_if.dev link,
    // Core side
    input wire logic fetchReq,
    input wire logic [`RSCB_ADDR_W-1:0] fetchAddr,
    output logic fetchDone,
    output logic [`RSCB_LINE_W-1:0] fetchData,
    output logic running,
    output logic [31:0] pc,
    output logic [31:0] instrWord,
    output logic wideBus,
    output logic [3:0] ratio,
    output logic [1:0] clkDelay
);
    localparam int BOOT_BITS = ICACHE_WORDS * 32;
    localparam int BW = $clog2(BOOT_BITS + 1);
    localparam int IW = $clog2(ICACHE_WORDS);
    localparam int PW = `RSCB_STRAP_W + 3;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [PW-1:0] s1, s2, s3, filt, next_filt;
    logic held;
    always_comb begin
        // A bit moves only once the second and third stages agree
        next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else begin
            s1 <= {link.straps, link.powerGood, link.resetIn_n, link.romData};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end
    assign held = ~filt[2] | ~filt[1]; // [RULE9]

    // ************************************************
    // Straps and clock generation
    // ************************************************
    logic [2:0] divSel, next_divSel;
    logic [1:0] next_clkDelay;
    logic next_wideBus;
    logic [3:0] next_ratio, divCnt, next_divCnt, highLen;
    logic corePhase, next_corePhase;
    logic [4:0] hist, next_hist;
    logic next_clkA, next_clkB;
    always_comb begin
        next_wideBus = wideBus;
        next_divSel = divSel;
        next_clkDelay = clkDelay;
        if (held) begin
            // Straps track the pins while held, frozen at release
            next_wideBus = filt[3 + `RSCB_WIDE_BIT]; // [RULE1] [RULE2] [RULE15]
            next_divSel = filt[3 + `RSCB_DIV_LSB +: 3];
            next_clkDelay = filt[3 + `RSCB_DLY_LSB +: 2];
        end
        if (next_divSel == `RSCB_DIV_SAT) begin
            next_ratio = `RSCB_RATIO_MAX; // [RULE3]
        end else begin
            next_ratio = {1'b0, next_divSel} + `RSCB_RATIO_MIN; // [RULE3]
        end
        next_corePhase = ~corePhase; // [RULE7]
        next_divCnt = divCnt;
        if (corePhase) begin
            // Wrap with >= so a ratio shrinking while held cannot stall
            if (divCnt >= ratio - 4'h1) begin
                next_divCnt = 4'h0;
            end else begin
                next_divCnt = divCnt + 4'h1;
            end
        end
        highLen = (ratio + 4'h1) >> 1;
        next_clkA = next_divCnt < highLen; // [RULE6]
        next_hist = {hist[3:0], link.clkAPos};
        // Clock B is clock A seen 2*delay oscillator edges later
        case (clkDelay)
            2'h0: next_clkB = next_clkA; // [RULE5]
            2'h1: next_clkB = hist[0];
            2'h2: next_clkB = hist[2];
            2'h3: next_clkB = hist[4];
            default: next_clkB = next_clkA;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wideBus <= 1'b0;
            divSel <= 3'h0;
            clkDelay <= 2'h0;
            ratio <= `RSCB_RATIO_MIN;
            corePhase <= 1'b0;
            divCnt <= 4'h0;
            hist <= 5'h0;
            link.clkAPos <= 1'b0;
            link.clkANeg <= 1'b1;
            link.clkBPos <= 1'b0;
            link.clkBNeg <= 1'b1;
        end else begin
            wideBus <= next_wideBus;
            divSel <= next_divSel;
            clkDelay <= next_clkDelay;
            ratio <= next_ratio;
            corePhase <= next_corePhase;
            divCnt <= next_divCnt;
            hist <= next_hist;
            link.clkAPos <= next_clkA; // [RULE4] [RULE6]
            link.clkANeg <= ~next_clkA; // [RULE6]
            link.clkBPos <= next_clkB;
            link.clkBNeg <= ~next_clkB;
        end
    end

    // ************************************************
    // Boot load, execution start and line fills
    // ************************************************
    rscb_pkg::rscb_dev_state_t state, next_state;
    logic [31:0] cache [ICACHE_WORDS];
    logic [2:0] romDiv, next_romDiv;
    logic [BW-1:0] bitCnt, next_bitCnt;
    logic [31:0] shiftWord, next_shiftWord;
    logic cacheWe;
    logic [IW-1:0] cacheIdx;
    logic next_romOe, next_romClk, next_fillReq, aRise;
    logic [`RSCB_ADDR_W-1:0] next_fillAddr;
    logic [2:0] beatCnt, next_beatCnt, lastBeat;
    logic [`RSCB_LINE_W-1:0] next_fetchData;
    logic next_fetchDone, next_running;
    logic [31:0] next_pc, next_instrWord;
    always_comb begin
        next_state = state;
        next_romDiv = romDiv;
        next_bitCnt = bitCnt;
        next_shiftWord = shiftWord;
        next_romOe = link.romOe;
        next_romClk = link.romClk;
        next_fillReq = link.fillReq;
        next_fillAddr = link.fillAddr;
        next_beatCnt = beatCnt;
        next_fetchData = fetchData;
        next_fetchDone = 1'b0;
        next_running = running;
        next_pc = pc;
        next_instrWord = cache[pc[IW+1:2]];
        cacheWe = 1'b0;
        cacheIdx = bitCnt[5 +: IW];
        aRise = link.clkAPos & ~hist[0];
        lastBeat = wideBus ? `RSCB_WIDE_BEATS : `RSCB_NARROW_BEATS; // [RULE2]
        case (state)
            rscb_pkg::DEV_HELD: begin
                if (!held) begin
                    next_state = rscb_pkg::DEV_BOOT; // [RULE11]
                    next_romOe = 1'b1; // [RULE12]
                    next_romDiv = 3'h0;
                    next_bitCnt = '0;
                end
            end
            rscb_pkg::DEV_BOOT: begin
                next_romDiv = romDiv + 3'h1;
                if (romDiv == `RSCB_ROM_HALF - 3'h1) begin
                    next_romDiv = 3'h0;
                    next_romClk = ~link.romClk; // [RULE12]
                    if (!link.romClk && bitCnt != BW'(BOOT_BITS)) begin
                        // Sample on the rising ROM clock, a full period after the rise that moved the bit
                        next_shiftWord = {shiftWord[30:0], filt[0]}; // [RULE12]
                        next_bitCnt = bitCnt + BW'(1);
                        cacheWe = bitCnt[4:0] == 5'h1F; // [RULE11]
                    end
                    if (link.romClk && bitCnt == BW'(BOOT_BITS)) begin
                        next_state = rscb_pkg::DEV_RUN;
                        next_romOe = 1'b0;
                        next_running = 1'b1;
                        next_pc = `RSCB_BOOT_PC; // [RULE13]
                    end
                end
            end
            rscb_pkg::DEV_RUN: begin
                if (fetchReq) begin
                    next_state = rscb_pkg::DEV_FILL;
                    next_fillAddr = fetchAddr;
                end
            end
            rscb_pkg::DEV_FILL: begin
                if (aRise && !link.fillReq) begin
                    next_fillReq = 1'b1; // [RULE4]
                    next_beatCnt = 3'h0;
                end else if (aRise && link.fillValid) begin
                    if (wideBus) begin
                        next_fetchData[beatCnt[0]*`RSCB_BUS_W +: `RSCB_BUS_W] =
                            link.fillData;
                    end else begin
                        next_fetchData[beatCnt[1:0]*`RSCB_NARROW_W +: `RSCB_NARROW_W] =
                            link.fillData[`RSCB_NARROW_W-1:0];
                    end
                    next_beatCnt = beatCnt + 3'h1;
                    if (beatCnt + 3'h1 == lastBeat) begin
                        next_fillReq = 1'b0;
                        next_fetchDone = 1'b1;
                        next_state = rscb_pkg::DEV_RUN;
                    end
                end
            end
            default: next_state = rscb_pkg::DEV_HELD;
        endcase
        if (held) begin
            next_state = rscb_pkg::DEV_HELD; // [RULE9]
            next_romOe = 1'b0;
            next_romClk = 1'b0;
            next_fillReq = 1'b0;
            next_running = 1'b0;
            next_fetchDone = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rscb_pkg::DEV_HELD;
            romDiv <= 3'h0;
            bitCnt <= '0;
            shiftWord <= 32'h0;
            link.romOe <= 1'b0;
            link.romClk <= 1'b0;
            link.fillReq <= 1'b0;
            link.fillAddr <= '0;
            beatCnt <= 3'h0;
            fetchData <= '0;
            fetchDone <= 1'b0;
            running <= 1'b0;
            pc <= `RSCB_BOOT_PC;
            instrWord <= 32'h0;
        end else begin
            state <= next_state;
            romDiv <= next_romDiv;
            bitCnt <= next_bitCnt;
            shiftWord <= next_shiftWord;
            link.romOe <= next_romOe;
            link.romClk <= next_romClk;
            link.fillReq <= next_fillReq;
            link.fillAddr <= next_fillAddr;
            beatCnt <= next_beatCnt;
            fetchData <= next_fetchData;
            fetchDone <= next_fetchDone;
            running <= next_running;
            pc <= next_pc;
            instrWord <= next_instrWord; // [RULE13]
        end
    end
    // Cache has no reset; only boot writes fill it
    always_ff @(posedge sys_clk) begin
        if (cacheWe) begin
            cache[cacheIdx] <= next_shiftWord;
        end
    end
endmodule // rscb_device
`default_nettype wire

// *** rtl/rscb_system.sv ***
// System logic end: straps, power-good, reset, boot ROM and line fills.
// Assumes the memory behind lineData answers in the same cycle that memRead is high.
`timescale 1ns/100ps
`default_nettype none
`include "rscb_params.svh"
module rscb_system #(
    parameter int ROM_BITS = 2048,
    parameter int SETTLE_CYC = `RSCB_REF_SETTLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    rscb_if.sys link,
    // Configuration and power
    input wire logic powerOn,
    input wire logic sysReset_n,
    input wire logic cfgWide,
    input wire logic [2:0] cfgDiv,
    input wire logic [1:0] cfgDelay,
    // Boot ROM image load
    input wire logic romWrEn,
    input wire logic [$clog2(ROM_BITS)-1:0] romWrAddr,
    input wire logic romWrBit,
    // Memory side
    output logic memRead,
    output logic [`RSCB_ADDR_W-1:0] memAddr,
    input wire logic [`RSCB_LINE_W-1:0] lineData
);
    localparam int RW = $clog2(ROM_BITS);
    localparam int SW = $clog2(SETTLE_CYC + 1);

    // ************************************************
    // Power, reset, straps and boot ROM
    // ************************************************
    logic romImg [ROM_BITS];
    logic [SW-1:0] settle, next_settle;
    logic [RW-1:0] romPtr, next_romPtr;
    logic romClkPrev, aPrev, aRise;
    always_comb begin
        next_settle = settle;
        if (!powerOn) begin
            next_settle = '0;
        end else if (settle != SW'(SETTLE_CYC)) begin
            next_settle = settle + SW'(1); // [RULE10]
        end
        next_romPtr = romPtr;
        if (!link.romOe) begin
            next_romPtr = '0;
        end else if (link.romClk && !romClkPrev) begin
            next_romPtr = romPtr + RW'(1);
        end
        aRise = link.clkAPos & ~aPrev; // [RULE4] [RULE8]
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle <= '0;
            romPtr <= '0;
            romClkPrev <= 1'b0;
            aPrev <= 1'b0;
            link.powerGood <= 1'b0;
            link.resetIn_n <= 1'b0;
            link.straps <= '0;
            link.romData <= 1'b0;
        end else begin
            settle <= next_settle;
            romPtr <= next_romPtr;
            romClkPrev <= link.romClk;
            aPrev <= link.clkAPos;
            link.powerGood <= next_settle == SW'(SETTLE_CYC); // [RULE10]
            link.resetIn_n <= sysReset_n;
            link.straps <= {cfgWide, cfgDelay, cfgDiv}; // [RULE1]
            link.romData <= romImg[next_romPtr];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (romWrEn) begin
            romImg[romWrAddr] <= romWrBit;
        end
    end

    // ************************************************
    // Line fill server
    // ************************************************
    rscb_pkg::rscb_sys_state_t state, next_state;
    logic [`RSCB_LINE_W-1:0] line, next_line;
    logic [2:0] beat, next_beat, nBeats;
    logic next_valid, next_memRead;
    logic [`RSCB_BUS_W-1:0] next_data;
    logic [`RSCB_ADDR_W-1:0] next_memAddr;
    always_comb begin
        next_state = state;
        next_line = line;
        next_beat = beat;
        next_valid = link.fillValid;
        next_data = link.fillData;
        next_memRead = 1'b0;
        next_memAddr = memAddr;
        // Bus width must match what the straps told the device
        nBeats = cfgWide ? `RSCB_WIDE_BEATS : `RSCB_NARROW_BEATS; // [RULE2]
        case (state)
            rscb_pkg::SYS_IDLE: begin
                if (aRise && link.fillReq) begin
                    next_memAddr = link.fillAddr;
                    next_memRead = 1'b1;
                    next_state = rscb_pkg::SYS_LOAD;
                end
            end
            rscb_pkg::SYS_LOAD: begin
                next_line = lineData;
                next_beat = 3'h0;
                next_state = rscb_pkg::SYS_SERVE;
            end
            rscb_pkg::SYS_SERVE: begin
                if (aRise) begin
                    if (beat == nBeats) begin
                        next_valid = 1'b0;
                        next_state = rscb_pkg::SYS_DONE;
                    end else begin
                        next_valid = 1'b1; // [RULE14]
                        if (cfgWide) begin
                            next_data = line[beat[0]*`RSCB_BUS_W +: `RSCB_BUS_W];
                        end else begin
                            next_data = {{(`RSCB_BUS_W-`RSCB_NARROW_W){1'b0}},
                                line[beat[1:0]*`RSCB_NARROW_W +: `RSCB_NARROW_W]};
                        end
                        next_beat = beat + 3'h1;
                    end
                end
            end
            rscb_pkg::SYS_DONE: begin
                if (!link.fillReq) begin
                    next_state = rscb_pkg::SYS_IDLE;
                end
            end
            default: next_state = rscb_pkg::SYS_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rscb_pkg::SYS_IDLE;
            line <= '0;
            beat <= 3'h0;
            link.fillValid <= 1'b0;
            link.fillData <= '0;
            memRead <= 1'b0;
            memAddr <= '0;
        end else begin
            state <= next_state;
            line <= next_line;
            beat <= next_beat;
            link.fillValid <= next_valid;
            link.fillData <= next_data;
            memRead <= next_memRead;
            memAddr <= next_memAddr;
        end
    end
endmodule // rscb_system
`default_nettype wire

// *** test/rscb_assertions.sv ***
// Checker for the link between the processor end and the system logic end.
// Assumes the bench wires it beside the interface on the single sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "rscb_params.svh"
module rscb_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    input wire logic [`RSCB_STRAP_W-1:0] straps,
    input wire logic powerGood,
    input wire logic resetIn_n,
    input wire logic clkAPos,
    input wire logic clkANeg,
    input wire logic clkBPos,
    input wire logic clkBNeg,
    input wire logic romOe,
    input wire logic romClk,
    input wire logic fillReq,
    input wire logic fillValid
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic [3:0] expRatio;
    logic [4:0] sinceRise;
    logic [1:0] bootRises;
    // Period is only judged between rises inside the boot, when straps are frozen
    always_comb begin
        expRatio = (straps[2:0] == 3'h7) ? 4'h8 : {1'b0, straps[2:0]} + 4'h2;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceRise <= 5'h0;
            bootRises <= 2'h0;
        end else begin
            sinceRise <= $rose(clkAPos) ? 5'h1 : sinceRise + 5'h1;
            if (!romOe)
                bootRises <= 2'h0;
            else if ($rose(clkAPos) && bootRises != 2'h3)
                bootRises <= bootRises + 2'h1;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_clka_pair: assert property (clkANeg == !clkAPos)
        else $error("clock A pair not complementary");
    chk_clkb_pair: assert property (clkBNeg == !clkBPos)
        else $error("clock B pair not complementary");
    chk_clka_period: assert property ($rose(clkAPos) && bootRises >= 2'h2 |->
        sinceRise == {expRatio, 1'b0}) else $error("clock A period wrong");
    chk_clkb_delay: assert property (bootRises == 2'h3 |-> clkBPos ==
        (straps[4:3] == 2'h0 ? clkAPos : straps[4:3] == 2'h1 ? $past(clkAPos, 2) :
        straps[4:3] == 2'h2 ? $past(clkAPos, 4) : $past(clkAPos, 6)))
        else $error("clock B delay wrong");
    chk_rom_gated: assert property (!romOe |-> !romClk)
        else $error("ROM clock outside boot");
    chk_rom_half: assert property ($rose(romClk) |-> romClk [*4] ##1 !romClk)
        else $error("ROM clock half period wrong");
    chk_boot_start: assert property ($rose(romOe) |-> powerGood && resetIn_n)
        else $error("boot began while held");
    chk_held_quiet: assert property (!powerGood [*6] |-> !romOe)
        else $error("boot while power not good");
    chk_no_fill_boot: assert property (romOe |-> !fillReq)
        else $error("fill during boot");
    cov_boot: cover property ($rose(romOe));
    cov_beat: cover property ($rose(fillValid));
    cov_fill_end: cover property ($fell(fillReq));
endmodule // rscb_assertions
`default_nettype wire

// *** test/tb.sv ***
// Testbench joining both ends of the strap, clock and boot link.
// Assumes short counts: two cache words, 64 ROM bits, 4 settle cycles.
`timescale 1ns/100ps
`default_nettype none
`include "rscb_params.svh"
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerOn = 1'b0;
    logic sysReset_n = 1'b0;
    logic cfgWide = 1'b0;
    logic [2:0] cfgDiv = 3'h0;
    logic [1:0] cfgDelay = 2'h0;
    logic romWrEn = 1'b0;
    logic [5:0] romWrAddr = 6'h0;
    logic romWrBit = 1'b0;
    logic fetchReq = 1'b0;
    logic [`RSCB_ADDR_W-1:0] fetchAddr = '0;
    logic [`RSCB_LINE_W-1:0] lineData = '0;
    logic fetchDone, running, wideBus, memRead;
    logic [`RSCB_LINE_W-1:0] fetchData;
    logic [31:0] pc, instrWord;
    logic [3:0] ratio;
    logic [1:0] clkDelay;
    logic [`RSCB_ADDR_W-1:0] memAddr;
    int errors = 0;
    int checked = 0;
    localparam logic [31:0] BOOT_WORD = 32'hA5C3_0F1E;
    always #4 sys_clk = ~sys_clk;
    rscb_if link();
    rscb_device #(.ICACHE_WORDS(2)) rscb_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(link), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchDone(fetchDone),
        .fetchData(fetchData), .running(running), .pc(pc), .instrWord(instrWord),
        .wideBus(wideBus), .ratio(ratio), .clkDelay(clkDelay));
    rscb_system #(.ROM_BITS(64), .SETTLE_CYC(4)) rscb_system_inst (.sys_clk(sys_clk),
        .rst_n(rst_n), .link(link), .powerOn(powerOn), .sysReset_n(sysReset_n),
        .cfgWide(cfgWide), .cfgDiv(cfgDiv), .cfgDelay(cfgDelay), .romWrEn(romWrEn),
        .romWrAddr(romWrAddr), .romWrBit(romWrBit), .memRead(memRead), .memAddr(memAddr),
        .lineData(lineData));
    rscb_assertions rscb_assertions_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .straps(link.straps), .powerGood(link.powerGood), .resetIn_n(link.resetIn_n),
        .clkAPos(link.clkAPos), .clkANeg(link.clkANeg), .clkBPos(link.clkBPos),
        .clkBNeg(link.clkBNeg), .romOe(link.romOe), .romClk(link.romClk),
        .fillReq(link.fillReq), .fillValid(link.fillValid));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset with new straps; the ROM image is written again although reset does not clear it
    task automatic restart(input int i);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        powerOn <= 1'b0;
        sysReset_n <= 1'b0;
        cfgWide <= i[0] ^ i[2];
        cfgDiv <= i[2:0];
        cfgDelay <= i[1:0];
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 64; k++) begin
            @(posedge sys_clk);
            romWrEn <= 1'b1;
            romWrAddr <= k[5:0];
            romWrBit <= (k < 32) ? BOOT_WORD[31-k] : k[0];
        end
        @(posedge sys_clk);
        romWrEn <= 1'b0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic held_stays;
        restart(2);
        @(posedge sys_clk);
        sysReset_n <= 1'b1;
        repeat (40) @(negedge sys_clk);
        check(running, 1'b0);
        check(link.romOe, 1'b0);
        @(posedge sys_clk);
        sysReset_n <= 1'b0;
        powerOn <= 1'b1;
        repeat (2) @(negedge sys_clk);
        check(link.powerGood, 1'b0);
        repeat (38) @(negedge sys_clk);
        check(link.powerGood, 1'b1);
        check(link.romOe, 1'b0);
    endtask
    task automatic boot_and_fill(input int i);
        int n;
        int reads;
        logic [3:0] expRatio;
        restart(i);
        expRatio = (i == 7) ? 4'h8 : 4'(i + 2);
        @(posedge sys_clk);
        powerOn <= 1'b1;
        sysReset_n <= 1'b1;
        n = 0;
        while (running !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        check(running, 1'b1);
        repeat (2) @(negedge sys_clk);
        check(pc, 32'h0);
        check(instrWord, BOOT_WORD);
        check(wideBus, i[0] ^ i[2]);
        check(ratio, expRatio);
        check(clkDelay, i[1:0]);
        @(posedge sys_clk);
        fetchReq <= 1'b1;
        fetchAddr <= 29'h0ABC_DE0 + 29'(i);
        lineData <= 256'h0123456789ABCDEFFEDCBA98765432100F1E2D3C4B5A69788796A5B4C3D2E1F0
            ^ 256'(i);
        @(posedge sys_clk);
        fetchReq <= 1'b0;
        n = 0;
        reads = 0;
        while (fetchDone !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
            reads += int'(memRead === 1'b1);
        end
        check(fetchDone, 1'b1);
        check(reads, 1);
        check(fetchData, lineData);
        check(memAddr, fetchAddr);
        @(posedge sys_clk);
        cfgDiv <= ~cfgDiv;
        cfgWide <= ~cfgWide;
        repeat (20) @(negedge sys_clk);
        check(ratio, expRatio);
        check(wideBus, i[0] ^ i[2]);
    endtask
    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        held_stays();
        for (int i = 0; i < 8; i++)
            boot_and_fill(i);
        end_of_test();
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end
endmodule // tb
`default_nettype wire
